// File: ftc_top.sv
// Flow processing, two totalizers, automatic functions and second output select
`timescale 1ns/100ps

module ftc_top #(
  parameter int PULSE_HALF_CYC = ftc_pkg::PULSE_HALF_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic signed [ftc_pkg::FLOW_W-1:0] flow_raw,
  input wire logic signed [ftc_pkg::FLOW_W-1:0] test_flow,
  input wire logic signed [ftc_pkg::TEMP_W-1:0] temp_raw,
  input wire logic meas_error,
  input wire logic logic_input,
  input wire ftc_pkg::ftc_primary_sel_t primary_function_selector,
  input wire ftc_pkg::ftc_secondary_sel_t secondary_function_selector,
  input wire logic [7:0] configuration_register_seven,
  input wire logic [ftc_pkg::LIN_N-1:0][15:0] lin_corr,
  input wire logic [ftc_pkg::FLOW_W-1:0] full_scale,
  input wire logic [15:0] tc_coeff,
  input wire logic [15:0] cur_gain,
  input wire logic signed [ftc_pkg::VOL_W-1:0] setpoint,
  input wire logic [ftc_pkg::VOL_W-1:0] pulse_quantum,
  input wire logic total_clear,
  input wire logic total_load,
  input wire logic batch_clear,
  input wire logic batch_load,
  input wire logic signed [ftc_pkg::VOL_W-1:0] preset_value,
  input wire logic direct_out,
  output logic signed [ftc_pkg::FLOW_W-1:0] flow_rate,
  output logic signed [ftc_pkg::FLOW_W-1:0] tc_flow,
  output logic signed [ftc_pkg::TEMP_W-1:0] temperature,
  output logic signed [ftc_pkg::VOL_W-1:0] total_volume_counter,
  output logic signed [ftc_pkg::VOL_W-1:0] batch_volume_counter,
  output logic second_digital_output,
  output logic [ftc_pkg::CUR_W-1:0] current_out,
  output logic batch_running
);

  // ----------------------------------------------------------------
  // Linearizing: pick the curve segment from the flow fraction
  // ----------------------------------------------------------------
  logic [31:0] abs_raw;
  logic [ftc_pkg::LIN_N-1:0] lin_ge;
  logic [2:0] idx_chain [ftc_pkg::LIN_N];
  assign abs_raw = flow_raw[31] ? 32'(-flow_raw) : 32'(flow_raw);
  assign lin_ge[0] = 1'b0;
  assign idx_chain[0] = 3'h0;
  for (genvar k = 1; k < ftc_pkg::LIN_N; k++) begin : g_lin
    assign lin_ge[k] = {abs_raw, 3'b000} >= 35'(35'(full_scale) * 35'(k));
    assign idx_chain[k] = idx_chain[k-1] + {2'b00, lin_ge[k]};
  end
  logic signed [15:0] lin_sel;
  logic signed [48:0] lin_prod;
  logic signed [31:0] lin_flow;
  assign lin_sel = lin_corr[idx_chain[ftc_pkg::LIN_N-1]];
  assign lin_prod = 49'(lin_sel) * $signed({17'h00000, full_scale});
  assign lin_flow = configuration_register_seven[ftc_pkg::LIN_EN_BIT] ?
                    flow_raw + 32'(lin_prod >>> ftc_pkg::LIN_SH) : flow_raw;

  // ----------------------------------------------------------------
  // Test substitution, cutoff, sign handling, filter
  // ----------------------------------------------------------------
  ftc_pkg::ftc_secondary_sel_t sec;
  ftc_pkg::ftc_out2_src_t src;
  logic signed [31:0] sel_flow;
  logic [31:0] abs_sel;
  logic [31:0] cut_thr;
  logic signed [31:0] clean_flow;
  logic signed [31:0] filt_ff;
  logic signed [31:0] nxt_filt;
  logic signed [31:0] flow_base;
  assign sec = secondary_function_selector;
  assign src = primary_function_selector.out2_src;
  assign sel_flow = primary_function_selector.test_mode ? test_flow : lin_flow;
  assign abs_sel = sel_flow[31] ? 32'(-sel_flow) : 32'(sel_flow);
  assign cut_thr = 32'((49'(full_scale) * 49'(ftc_pkg::LOWCUT_NUM)) >> ftc_pkg::LOWCUT_SH);
  assign clean_flow = ((sec.low_cut && abs_sel < cut_thr) ||
                       (sec.neg_zero && sel_flow[31])) ? 32'sh0 : sel_flow;
  assign nxt_filt = filt_ff + ((clean_flow - filt_ff) >>> ftc_pkg::FILT_SH);
  assign flow_base = sec.filter_en ? nxt_filt : clean_flow;

  // ----------------------------------------------------------------
  // Temperature compensation, unit scaling, temperature display
  // ----------------------------------------------------------------
  logic signed [16:0] dtemp;
  logic signed [34:0] tc_factor;
  logic signed [66:0] tc_prod;
  logic signed [31:0] tc_base;
  logic signed [47:0] rate_min;
  logic signed [47:0] tc_min;
  logic signed [34:0] fahr_prod;
  logic signed [15:0] temp_disp;
  assign dtemp = 17'(temp_raw) - ftc_pkg::TC_REF_DECI_C;
  assign tc_factor = ftc_pkg::TC_UNITY - 35'($signed({1'b0, tc_coeff}) * dtemp);
  assign tc_prod = 67'(flow_base) * 67'(tc_factor);
  assign tc_base = sec.tcomp_en ? 32'(tc_prod >>> ftc_pkg::TC_SH) : flow_base;
  assign rate_min = (48'(flow_base) * 48'(ftc_pkg::MIN_MUL)) >>> ftc_pkg::MIN_SH;
  assign tc_min = (48'(tc_base) * 48'(ftc_pkg::MIN_MUL)) >>> ftc_pkg::MIN_SH;
  assign fahr_prod = 35'(temp_raw) * 35'(ftc_pkg::FAHR_MUL);
  assign temp_disp = sec.fahrenheit ?
                     16'(fahr_prod >>> ftc_pkg::FAHR_SH) + ftc_pkg::FAHR_OFS : temp_raw;

  // ----------------------------------------------------------------
  // Totalizers and batch control
  // ----------------------------------------------------------------
  logic count_en;
  logic in_prev_ff;
  logic batch_start;
  logic signed [47:0] nxt_total;
  logic signed [47:0] nxt_batch;
  logic signed [47:0] batch_sum;
  logic nxt_running;
  assign count_en = sample_valid && !(sec.in_func == ftc_pkg::IN_STOP && logic_input);
  assign batch_start = logic_input && !in_prev_ff && sec.in_func == ftc_pkg::IN_BATCH &&
                       src == ftc_pkg::OUT2_BATCH;
  assign nxt_total = total_clear ? 48'sh0 : total_load ? preset_value :
                     count_en ? total_volume_counter + 48'(flow_base) : total_volume_counter;
  assign batch_sum = batch_volume_counter + 48'(flow_base);
  assign nxt_batch = (batch_clear || batch_start) ? 48'sh0 : batch_load ? preset_value :
                     count_en ? batch_sum : batch_volume_counter;
  assign nxt_running = batch_start ? 1'b1 :
                       (nxt_batch >= setpoint) ? 1'b0 : batch_running;

  // ----------------------------------------------------------------
  // Slow pulse: quantum counting and timed pulse shaping
  // ----------------------------------------------------------------
  ftc_pkg::ftc_pulse_st_t pst_ff;
  ftc_pkg::ftc_pulse_st_t nxt_pst;
  logic [31:0] ptim_ff;
  logic [31:0] nxt_ptim;
  logic [47:0] qacc_ff;
  logic [47:0] qsum;
  logic q_hit;
  logic [7:0] pend_ff;
  logic pend_take;
  logic [7:0] nxt_pend;
  assign qsum = qacc_ff + 48'(flow_base);
  assign q_hit = count_en && !flow_base[31] && pulse_quantum != 48'h0 &&
                 qsum >= pulse_quantum;
  assign pend_take = pst_ff == ftc_pkg::PS_IDLE && pend_ff != 8'h00;
  // A full queue still takes a pulse when one leaves in the same cycle
  assign nxt_pend = pend_ff + {7'h00, q_hit && (pend_ff != ftc_pkg::PEND_MAX || pend_take)} -
                    {7'h00, pend_take};
  always_comb begin
    nxt_pst = pst_ff;
    nxt_ptim = ptim_ff;
    unique case (pst_ff)
      ftc_pkg::PS_IDLE: begin
        if (pend_take) begin
          nxt_pst = ftc_pkg::PS_HIGH;
          nxt_ptim = 32'(PULSE_HALF_CYC - 1);
        end
      end
      ftc_pkg::PS_HIGH: begin
        if (ptim_ff == 32'h0) begin
          nxt_pst = ftc_pkg::PS_LOW;
          nxt_ptim = 32'(PULSE_HALF_CYC - 1);
        end else begin
          nxt_ptim = ptim_ff - 32'h1;
        end
      end
      ftc_pkg::PS_LOW: begin
        if (ptim_ff == 32'h0) begin
          nxt_pst = ftc_pkg::PS_IDLE;
        end else begin
          nxt_ptim = ptim_ff - 32'h1;
        end
      end
      default: begin
        nxt_pst = ftc_pkg::PS_IDLE;
        nxt_ptim = 32'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // PI flow control and current output
  // ----------------------------------------------------------------
  logic signed [47:0] integ_ff;
  logic signed [47:0] pi_err;
  logic signed [47:0] nxt_integ;
  logic signed [47:0] pi_sum;
  logic signed [47:0] prop_cur;
  logic pi_mode;
  logic pi_manual;
  logic [15:0] nxt_cur;
  assign pi_mode = src == ftc_pkg::OUT2_FLOW_CTRL;
  // Manual mode freezes the integrator and holds the last current
  assign pi_manual = sec.in_func == ftc_pkg::IN_MANUAL && logic_input;
  assign pi_err = setpoint - 48'(flow_base);
  assign nxt_integ = integ_ff + (pi_err >>> ftc_pkg::PI_KI_SH);
  assign pi_sum = (pi_err >>> ftc_pkg::PI_KP_SH) + nxt_integ;
  assign prop_cur = (48'(abs_sel) * 48'(cur_gain)) >>> ftc_pkg::CUR_SH;
  always_comb begin
    nxt_cur = current_out;
    if (pi_mode) begin
      if (sample_valid && !pi_manual) begin
        nxt_cur = pi_sum[47] ? ftc_pkg::CUR_RST :
                  (pi_sum > 48'(ftc_pkg::CUR_MAX)) ? ftc_pkg::CUR_MAX : 16'(pi_sum);
      end
    end else if (sample_valid) begin
      // Follows the linearized flow magnitude ahead of cutoff and filter, test mode included
      nxt_cur = (prop_cur > 48'(ftc_pkg::CUR_MAX)) ? ftc_pkg::CUR_MAX : 16'(prop_cur);
    end
  end

  // ----------------------------------------------------------------
  // Second output source select
  // ----------------------------------------------------------------
  logic nxt_out2;
  assign nxt_out2 = (src == ftc_pkg::OUT2_SLOW_PULSE) ? pst_ff == ftc_pkg::PS_HIGH :
                    (src == ftc_pkg::OUT2_SIGN) ? flow_rate[31] :
                    (src == ftc_pkg::OUT2_BATCH) ? batch_running :
                    (src == ftc_pkg::OUT2_LIMIT) ? flow_rate >= 32'(setpoint) :
                    (src == ftc_pkg::OUT2_ERR_FREE) ? !meas_error :
                    (src == ftc_pkg::OUT2_DIRECT) ? direct_out : 1'b0;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      filt_ff <= 32'sh0;
      flow_rate <= 32'sh0;
      tc_flow <= 32'sh0;
      temperature <= 16'sh0;
    end else if (sample_valid) begin
      filt_ff <= nxt_filt;
      flow_rate <= sec.per_minute ? 32'(rate_min) : flow_base;
      tc_flow <= sec.per_minute ? 32'(tc_min) : tc_base;
      temperature <= temp_disp;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      total_volume_counter <= 48'sh0;
      batch_volume_counter <= 48'sh0;
      batch_running <= 1'b0;
      in_prev_ff <= 1'b0;
      second_digital_output <= 1'b0;
      current_out <= ftc_pkg::CUR_RST;
    end else begin
      total_volume_counter <= nxt_total;
      batch_volume_counter <= nxt_batch;
      batch_running <= nxt_running;
      in_prev_ff <= logic_input;
      second_digital_output <= nxt_out2;
      current_out <= nxt_cur;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pst_ff <= ftc_pkg::PS_IDLE;
      ptim_ff <= 32'h0;
      qacc_ff <= 48'h0;
      pend_ff <= 8'h00;
      integ_ff <= 48'sh0;
    end else begin
      pst_ff <= nxt_pst;
      ptim_ff <= nxt_ptim;
      qacc_ff <= q_hit ? qsum - pulse_quantum : (count_en && !flow_base[31]) ? qsum : qacc_ff;
      pend_ff <= nxt_pend;
      integ_ff <= (pi_mode && sample_valid && !pi_manual) ? nxt_integ : integ_ff;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_low_cut;
    @(posedge mclk) disable iff (rst)
    sample_valid && sec.low_cut && !sec.filter_en && !primary_function_selector.test_mode &&
    abs_sel < cut_thr |=> flow_rate == 32'sh0;
  endproperty
  a_low_cut: assert property (p_low_cut) else $error("small flow not cut");

  property p_neg_zero;
    @(posedge mclk) disable iff (rst)
    sample_valid && sec.neg_zero && !sec.filter_en |=> !flow_rate[31];
  endproperty
  a_neg_zero: assert property (p_neg_zero) else $error("negative flow passed");

  property p_total_clear;
    @(posedge mclk) disable iff (rst)
    total_clear && !batch_clear && !batch_load && !batch_start && !count_en
    |=> total_volume_counter == 48'sh0 && $stable(batch_volume_counter);
  endproperty
  a_total_clear: assert property (p_total_clear) else $error("clear not independent");

  property p_total_load;
    @(posedge mclk) disable iff (rst)
    !total_clear && total_load |=> total_volume_counter == $past(preset_value);
  endproperty
  a_total_load: assert property (p_total_load) else $error("preset not loaded");

  property p_batch_start;
    @(posedge mclk) disable iff (rst)
    batch_start |=> batch_running && batch_volume_counter == 48'sh0 ##1 second_digital_output;
  endproperty
  a_batch_start: assert property (p_batch_start) else $error("batch did not start");

  property p_batch_end;
    @(posedge mclk) disable iff (rst)
    batch_running && !batch_start && nxt_batch >= setpoint |=> !batch_running;
  endproperty
  a_batch_end: assert property (p_batch_end) else $error("batch did not stop");

  property p_sign;
    @(posedge mclk) disable iff (rst)
    src == ftc_pkg::OUT2_SIGN |=> second_digital_output == $past(flow_rate[31]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign output wrong");

  property p_err_free;
    @(posedge mclk) disable iff (rst)
    src == ftc_pkg::OUT2_ERR_FREE && meas_error |=> !second_digital_output;
  endproperty
  a_err_free: assert property (p_err_free) else $error("error-free set during error");

  property p_direct;
    @(posedge mclk) disable iff (rst)
    src == ftc_pkg::OUT2_DIRECT |=> second_digital_output == $past(direct_out);
  endproperty
  a_direct: assert property (p_direct) else $error("direct output not followed");

  property p_pulse_high;
    @(posedge mclk) disable iff (rst)
    pst_ff == ftc_pkg::PS_HIGH && ptim_ff == 32'h0 |=> pst_ff == ftc_pkg::PS_LOW &&
    ptim_ff == 32'(PULSE_HALF_CYC - 1);
  endproperty
  a_pulse_high: assert property (p_pulse_high) else $error("pulse low phase wrong");

  property p_temp_c;
    @(posedge mclk) disable iff (rst)
    sample_valid && !sec.fahrenheit |=> temperature == $past(temp_raw);
  endproperty
  a_temp_c: assert property (p_temp_c) else $error("celsius readout wrong");

  c_batch_run: cover property (@(posedge mclk) disable iff (rst) batch_start ##[1:50] !batch_running);
  c_pulse: cover property (@(posedge mclk) disable iff (rst) pst_ff == ftc_pkg::PS_HIGH);
  c_limit: cover property (@(posedge mclk) disable iff (rst)
    src == ftc_pkg::OUT2_LIMIT && $rose(second_digital_output));

endmodule : ftc_top

// File: ftc_pkg.sv
// Constants, selector layouts and state types of the flow totalizer block
package ftc_pkg;

  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int FLOW_W = 32;
  localparam int VOL_W = 48;
  localparam int CUR_W = 16;
  localparam int TEMP_W = 16;
  localparam int LIN_N = 8;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Processing constants
  // ----------------------------------------------------------------
  // 131/65536 of full scale is just under 0.2 %
  localparam logic [16:0] LOWCUT_NUM = 17'h00083;
  localparam int LOWCUT_SH = 16;
  localparam int FILT_SH = 4;
  // Reference temperature 4.0 degC, in tenths
  localparam logic signed [16:0] TC_REF_DECI_C = 17'sh00028;
  localparam logic signed [34:0] TC_UNITY = 35'sh000010000;
  localparam int TC_SH = 16;
  // 117965/65536 = 1.8
  localparam logic signed [18:0] FAHR_MUL = 19'sh1cccd;
  localparam int FAHR_SH = 16;
  localparam logic signed [TEMP_W-1:0] FAHR_OFS = 16'sh0140;
  // 17476/2^20 is 1/60
  localparam logic signed [15:0] MIN_MUL = 16'sh4444;
  localparam int MIN_SH = 20;
  localparam int LIN_SH = 16;
  localparam int LIN_EN_BIT = 5;
  localparam int PI_KP_SH = 8;
  localparam int PI_KI_SH = 12;
  localparam int CUR_SH = 16;
  localparam logic [CUR_W-1:0] CUR_RST = 16'h0000;
  localparam logic [CUR_W-1:0] CUR_MAX = 16'hffff;
  localparam logic [7:0] PEND_MAX = 8'hff;

  // ----------------------------------------------------------------
  // Slow pulse timing: at most 10 pulses per second
  // ----------------------------------------------------------------
  localparam int PULSE_MAX_HZ = 10;
  localparam int PULSE_HALF_CYC = CLK_HZ / (2 * PULSE_MAX_HZ);

  // ----------------------------------------------------------------
  // Selectors and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OUT2_SLOW_PULSE = 3'h0,
    OUT2_SIGN = 3'h1,
    OUT2_BATCH = 3'h2,
    OUT2_LIMIT = 3'h3,
    OUT2_ERR_FREE = 3'h4,
    OUT2_DIRECT = 3'h5,
    OUT2_FLOW_CTRL = 3'h6
  } ftc_out2_src_t;

  typedef struct packed {
    logic test_mode;
    ftc_out2_src_t out2_src;
  } ftc_primary_sel_t;

  typedef enum logic [1:0] {
    IN_NONE = 2'b00,
    IN_STOP = 2'b01,
    IN_BATCH = 2'b10,
    IN_MANUAL = 2'b11
  } ftc_in_func_t;

  typedef struct packed {
    logic low_cut;
    logic neg_zero;
    logic filter_en;
    logic tcomp_en;
    logic fahrenheit;
    logic per_minute;
    ftc_in_func_t in_func;
  } ftc_secondary_sel_t;

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_HIGH = 2'b01,
    PS_LOW = 2'b10
  } ftc_pulse_st_t;

endpackage : ftc_pkg

// File: ftc_ext_counter.sv
// External volume counter model watching the second digital output
`timescale 1ns/100ps
module ftc_ext_counter (
  input wire logic mclk,
  input wire logic rst,
  input wire logic arm,
  input wire logic second_digital_output,
  output int pulse_cnt,
  output int min_high,
  output int min_low
);
  logic prev_ff;
  int run_ff;
  // --------------------------------------------------------------
  // Pulse counting
  // --------------------------------------------------------------
  // Counts on rising edges; a low phase is timed only between pulses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
      run_ff <= 0;
      pulse_cnt <= 0;
      min_high <= 9999;
      min_low <= 9999;
    end else begin
      prev_ff <= second_digital_output;
      if (!arm) begin
        run_ff <= 0;
        pulse_cnt <= 0;
        min_high <= 9999;
        min_low <= 9999;
      end else if (second_digital_output !== prev_ff) begin
        run_ff <= 1;
        if (prev_ff && run_ff < min_high) min_high <= run_ff;
        if (!prev_ff) pulse_cnt <= pulse_cnt + 1;
        if (!prev_ff && pulse_cnt > 0 && run_ff < min_low) min_low <= run_ff;
      end else begin
        run_ff <= run_ff + 1;
      end
    end
  end
endmodule : ftc_ext_counter

// File: ftc_top_tb_top.sv
// Self-checking bench for the flow totalizer block
`timescale 1ns/100ps
module ftc_top_tb_top;
  localparam int HALF = 4;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sample_valid = 1'b0;
  logic signed [31:0] flow_raw = '0;
  logic signed [31:0] test_flow = '0;
  logic signed [15:0] temp_raw = '0;
  logic meas_error = 1'b0;
  logic logic_input = 1'b0;
  ftc_pkg::ftc_primary_sel_t prim = '0;
  ftc_pkg::ftc_secondary_sel_t sec = '0;
  logic [7:0] cfg7 = '0;
  logic [7:0][15:0] lin = '0;
  logic [31:0] fs = 32'h00100000;
  logic [15:0] tcc = '0;
  logic [15:0] gain = 16'h8000;
  logic signed [47:0] setp = '0;
  logic [47:0] quant = '0;
  logic tclr = 1'b0, tld = 1'b0, bclr = 1'b0, bld = 1'b0, direct = 1'b0, arm = 1'b0;
  logic signed [47:0] preset = '0;
  logic signed [31:0] flow_rate, tc_flow;
  logic signed [15:0] temperature;
  logic signed [47:0] total_volume_counter, batch_volume_counter;
  logic second_digital_output, batch_running;
  logic [15:0] current_out;
  int pulse_cnt, min_high, min_low, n_fail, n_tests, cycles, rs;
  longint tot, bat, thr, filt;
  int thr_cases[4] = '{2095, -2095, 2097, -2097};

  ftc_top #(.PULSE_HALF_CYC(HALF)) ftc_top_inst (
    .mclk(mclk), .rst(rst), .sample_valid(sample_valid), .flow_raw(flow_raw),
    .test_flow(test_flow), .temp_raw(temp_raw), .meas_error(meas_error),
    .logic_input(logic_input), .primary_function_selector(prim),
    .secondary_function_selector(sec), .configuration_register_seven(cfg7),
    .lin_corr(lin), .full_scale(fs), .tc_coeff(tcc), .cur_gain(gain), .setpoint(setp),
    .pulse_quantum(quant), .total_clear(tclr), .total_load(tld), .batch_clear(bclr),
    .batch_load(bld), .preset_value(preset), .direct_out(direct), .flow_rate(flow_rate),
    .tc_flow(tc_flow), .temperature(temperature), .total_volume_counter(total_volume_counter),
    .batch_volume_counter(batch_volume_counter), .current_out(current_out),
    .second_digital_output(second_digital_output), .batch_running(batch_running));

  ftc_ext_counter ftc_ext_counter_inst (.mclk(mclk), .rst(rst), .arm(arm),
    .second_digital_output(second_digital_output), .pulse_cnt(pulse_cnt),
    .min_high(min_high), .min_low(min_low));

  always #2.5 mclk = ~mclk;

  // --------------------------------------------------------------
  // Checking and pacing
  // --------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  // Model of one sample through the flow path and both totalizers
  task automatic samp(input logic signed [31:0] f);
    longint p, c, q, tc;
    int ix;
    q = (f < 0) ? -longint'(f) : longint'(f);
    ix = 0;
    for (int k = 1; k < 8; k++) begin
      if (q * 8 >= longint'(fs) * k) ix++;
    end
    p = f;
    if (cfg7[5]) p += ($signed(lin[ix]) * longint'(fs)) >>> ftc_pkg::LIN_SH;
    p = prim.test_mode ? test_flow : p;
    // Current follows the flow ahead of cutoff and sign handling
    c = ((p < 0 ? -p : p) * longint'(gain)) >> 16;
    if (c > 65535) c = 65535;
    if (sec.low_cut && (p < 0 ? -p : p) < thr) p = 0;
    if (sec.neg_zero && p < 0) p = 0;
    filt += (p - filt) >>> ftc_pkg::FILT_SH;
    if (sec.filter_en) p = filt;
    tc = int'((p * (ftc_pkg::TC_UNITY - longint'(tcc) *
      (longint'(temp_raw) - ftc_pkg::TC_REF_DECI_C))) >>> ftc_pkg::TC_SH);
    if (!sec.tcomp_en) tc = p;
    if (!(sec.in_func == ftc_pkg::IN_STOP && logic_input)) begin
      tot += p;
      bat += p;
    end
    flow_raw = f;
    sample_valid = 1'b1;
    cyc(1);
    sample_valid = 1'b0;
    cyc(4);
    chk(total_volume_counter, tot);
    chk(batch_volume_counter, bat);
    if (sec.per_minute) p = (p * ftc_pkg::MIN_MUL) >>> ftc_pkg::MIN_SH;
    chk(flow_rate, p);
    if (sec.per_minute) tc = (tc * ftc_pkg::MIN_MUL) >>> ftc_pkg::MIN_SH;
    chk(tc_flow, tc);
    chk(temperature, sec.fahrenheit ? ((longint'(temp_raw) * ftc_pkg::FAHR_MUL)
      >>> ftc_pkg::FAHR_SH) + ftc_pkg::FAHR_OFS : temp_raw);
    if (!sec.per_minute && prim.out2_src != ftc_pkg::OUT2_FLOW_CTRL) chk(current_out, c);
  endtask : samp

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rs = $urandom(32'hd19ccd66);
    thr = (longint'(fs) * 131) >> 16;
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    chk(total_volume_counter, 0);
    chk(second_digital_output, 0);
    sec.low_cut = 1'b1;
    for (int i = 0; i < 12; i++) begin
      sec.neg_zero = i[0];
      sec.filter_en = i[1];
      sec.tcomp_en = i[2];
      cfg7 = 8'($urandom);
      tcc = 16'($urandom);
      lin[i % 8] = 16'($urandom);
      temp_raw = 16'($urandom_range(900, 0));
      samp($signed($urandom_range(2097152, 0)) - 1048576);
    end
    sec = '0;
    sec.low_cut = 1'b1;
    cfg7 = 8'h00;
    foreach (thr_cases[k]) samp(thr_cases[k]);
    // Counting halts while the stop input is active
    sec.in_func = ftc_pkg::IN_STOP;
    logic_input = 1'b1;
    samp(5000);
    logic_input = 1'b0;
    samp(5000);
    sec = '0;
    // Clear and preset act on one totalizer only; clear beats load
    preset = 48'sh123456;
    tld = 1'b1;
    cyc(1);
    tld = 1'b0;
    cyc(2);
    tot = preset;
    chk(total_volume_counter, tot);
    chk(batch_volume_counter, bat);
    bclr = 1'b1;
    bld = 1'b1;
    cyc(1);
    {bclr, bld} = 2'b00;
    cyc(2);
    bat = 0;
    chk(batch_volume_counter, bat);
    chk(total_volume_counter, tot);
    tclr = 1'b1;
    tld = 1'b1;
    cyc(1);
    {tclr, tld} = 2'b00;
    cyc(2);
    tot = 0;
    chk(total_volume_counter, tot);
    chk(batch_volume_counter, bat);
    prim.test_mode = 1'b1;
    test_flow = -1000;
    samp(777);
    prim.test_mode = 1'b0;
    prim.out2_src = ftc_pkg::OUT2_SIGN;
    samp(-3000);
    chk(second_digital_output, 1);
    samp(3000);
    chk(second_digital_output, 0);
    setp = 48'sd4000;
    prim.out2_src = ftc_pkg::OUT2_LIMIT;
    samp(3999);
    chk(second_digital_output, 0);
    samp(4000);
    chk(second_digital_output, 1);
    prim.out2_src = ftc_pkg::OUT2_ERR_FREE;
    for (int e = 0; e < 2; e++) begin
      meas_error = e[0];
      cyc(3);
      chk(second_digital_output, !e[0]);
    end
    prim.out2_src = ftc_pkg::OUT2_DIRECT;
    for (int d = 0; d < 2; d++) begin
      direct = d[0];
      cyc(3);
      chk(second_digital_output, d[0]);
    end
    // Controller mode: a far-off setpoint drives the current to full scale
    setp = 48'sh7fffffff;
    prim.out2_src = ftc_pkg::OUT2_FLOW_CTRL;
    samp(0);
    chk(current_out, 16'hffff);
    chk(second_digital_output, 0);
    // Manual mode holds the current although the setpoint now asks for zero
    sec.in_func = ftc_pkg::IN_MANUAL;
    logic_input = 1'b1;
    setp = -48'sh7fffffff;
    samp(0);
    chk(current_out, 16'hffff);
    logic_input = 1'b0;
    sec.fahrenheit = 1'b1;
    sec.per_minute = 1'b1;
    temp_raw = 16'sd100;
    samp(6000);
    sec = '0;
    // Batch run: 30 per sample against a setpoint of 100
    setp = 48'sd100;
    prim.out2_src = ftc_pkg::OUT2_BATCH;
    sec.in_func = ftc_pkg::IN_BATCH;
    logic_input = 1'b1;
    cyc(3);
    bat = 0;
    chk(batch_running, 1);
    chk(second_digital_output, 1);
    chk(batch_volume_counter, 0);
    for (int i = 1; i <= 4; i++) begin
      samp(30);
      chk(batch_running, i < 4);
      chk(second_digital_output, i < 4);
    end
    logic_input = 1'b0;
    // Slow pulses: one per quantum, paced by the half period
    sec.in_func = ftc_pkg::IN_NONE;
    prim.out2_src = ftc_pkg::OUT2_SLOW_PULSE;
    quant = 48'd1000;
    arm = 1'b1;
    cyc(2);
    repeat (5) samp(1000);
    cyc(60);
    chk(pulse_cnt, 5);
    chk(min_high, HALF);
    chk(min_low >= HALF, 1);
    conclude();
  end

endmodule : ftc_top_tb_top
